// ### core/led_params.svh
// Constants for the LED pump and backlight controller: register indices,
// reset values, field positions, timing and mode-selection thresholds.
// Assumes it is included by bare name before any module that uses it.
`ifndef LED_PARAMS_SVH
`define LED_PARAMS_SVH

// Register indices; the APB byte address is the index shifted left by two
`define REG_IDX_CURRENT   8'h00
`define REG_IDX_ENABLE    8'h01
`define REG_IDX_FLASH     8'h02
`define REG_IDX_STATUS    8'h03
`define REG_BYTE_SHIFT    2

// Reset values
`define CURRENT_RESET     8'h00
`define ENABLE_RESET      4'h0
`define FLASH_RESET       5'h10

// Field layout
`define SINK_COUNT        4
`define LEVEL_MSB         4
`define FLASH_LEVEL_MSB   3
`define FLASH_LEVEL_LSB   1

// Level code to current in 0.5 mA units
`define LINEAR_TOP_CODE   5'h17
`define MID_TOP_CODE      5'h1a
`define HALF_MA_AT_12     6'h18
`define HALF_MA_AT_15     6'h1e
`define HALF_MA_MIN       6'h01
`define HALF_MA_MAX       6'h32

// Clock and pump switching rate
`define CLK_HZ            10000000
`define PUMP_HZ           250000
`define PUMP_HALF_CYCLES  (`CLK_HZ / (2 * `PUMP_HZ))

// Sink headroom thresholds for ratio changes (up below, down above)
`define UP_1X_TO_1P5X     8'h20
`define DOWN_1P5X_TO_1X   8'h40
`define UP_1P5X_TO_2X     8'h18
`define DOWN_2X_TO_1P5X   8'h38

`endif

// ### core/led_pkg.sv
// Types shared by the LED pump and backlight controller.
// Assumes nothing beyond a SystemVerilog compiler.
package led_pkg;

  // Pump multiplication ratio
  typedef enum logic [1:0] {
    MODE_1X,
    MODE_1P5X,
    MODE_2X
  } pump_mode_type;

  // Register selected by an APB address
  typedef enum logic [2:0] {
    SEL_CURRENT,
    SEL_ENABLE,
    SEL_FLASH,
    SEL_STATUS,
    SEL_NONE
  } reg_sel_type;

endpackage

// ### core/led_pump_backlight_control.sv
// LED pump and backlight controller: APB registers, four backlight sinks,
// flash sink, automatic pump ratio and pump switching clock.
// Assumes pins are asynchronous; headroom words come from a sampler on pclk.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns
`include "led_params.svh"

module led_pump_backlight_control #(
  parameter int ADDR_W = 8,
  parameter int HEAD_W = 8
) (
  // APB clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [ADDR_W-1:0]                   paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Pins
  input  wire logic                                chip_enable_pin,
  input  wire logic                                flash_trigger_pin,
  // Sink headroom samples
  input  wire logic [`SINK_COUNT-1:0][HEAD_W-1:0]  backlight_headroom,
  input  wire logic [HEAD_W-1:0]                   flash_headroom,
  // Sink controls
  output logic                                     backlight_sink_output_1,
  output logic                                     backlight_sink_output_2,
  output logic                                     backlight_sink_output_3,
  output logic                                     backlight_sink_output_4,
  output logic      [5:0]                          backlight_level_half_ma,
  output logic                                     flash_sink_output,
  output logic      [2:0]                          flash_level,
  // Pump
  output led_pkg::pump_mode_type                   pump_mode,
  output logic                                     pump_clk,
  output logic                                     sleep_active
);

  localparam int DIV_W = $clog2(`PUMP_HALF_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Address to register select, word aligned only
  function automatic led_pkg::reg_sel_type decode_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a >> `REG_BYTE_SHIFT;
    if (a[1:0] != 2'h0) return led_pkg::SEL_NONE;
    case (idx)
      ADDR_W'(`REG_IDX_CURRENT): return led_pkg::SEL_CURRENT;
      ADDR_W'(`REG_IDX_ENABLE):  return led_pkg::SEL_ENABLE;
      ADDR_W'(`REG_IDX_FLASH):   return led_pkg::SEL_FLASH;
      ADDR_W'(`REG_IDX_STATUS):  return led_pkg::SEL_STATUS;
      default:                   return led_pkg::SEL_NONE;
    endcase
  endfunction

  // Level code to sink current in 0.5 mA units
  function automatic logic [5:0] half_ma_of(input logic [4:0] c);
    logic [5:0] off;
    off = 6'h00;
    if (c <= `LINEAR_TOP_CODE) begin
      return {1'b0, c} + `HALF_MA_MIN;
    end else if (c <= `MID_TOP_CODE) begin
      off = {1'b0, c} - {1'b0, `LINEAR_TOP_CODE};
      return `HALF_MA_AT_12 + 6'(off << 1);
    end else begin
      off = {1'b0, c} - {1'b0, `MID_TOP_CODE};
      return `HALF_MA_AT_15 + 6'(off << 2);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic en_meta_reg;
  logic en_sync_reg;
  logic fl_meta_reg;
  logic fl_sync_reg;

  // Two flops per pin; only the second is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
      fl_meta_reg <= 1'b0;
      fl_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= chip_enable_pin;
      en_sync_reg <= en_meta_reg;
      fl_meta_reg <= flash_trigger_pin;
      fl_sync_reg <= fl_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and registers

  logic [7:0]            current_reg;
  logic [7:0]            current_next;
  logic [3:0]            enable_reg;
  logic [3:0]            enable_next;
  logic [4:0]            flash_reg;
  logic [4:0]            flash_next;
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;
  logic                  pready_reg;
  logic                  pready_next;
  logic                  pslverr_reg;
  logic                  pslverr_next;
  logic                  setup_phase;
  logic                  write_now;
  logic [31:0]           status_word;
  led_pkg::reg_sel_type  sel;
  led_pkg::pump_mode_type mode_now;
  logic                  bl_any;
  logic                  flash_on_reg;
  logic                  sleep_reg;

  assign sel         = decode_sel(paddr);
  assign setup_phase = psel && !penable;
  assign write_now   = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign status_word = {27'h0000000, en_sync_reg, flash_on_reg, sleep_reg, mode_now};

  // Answer one cycle after setup; writes land at the access edge
  always_comb begin
    pready_next  = setup_phase;
    pslverr_next = setup_phase && (sel == led_pkg::SEL_NONE ||
                                   (pwrite && sel == led_pkg::SEL_STATUS));
    prdata_next  = prdata_reg;
    if (setup_phase && !pwrite) begin
      case (sel)
        led_pkg::SEL_CURRENT: prdata_next = {24'h000000, current_reg};
        led_pkg::SEL_ENABLE:  prdata_next = {28'h0000000, enable_reg};
        led_pkg::SEL_FLASH:   prdata_next = {27'h0000000, flash_reg};
        led_pkg::SEL_STATUS:  prdata_next = status_word;
        default:              prdata_next = 32'h00000000;
      endcase
    end
    current_next = current_reg;
    enable_next  = enable_reg;
    flash_next   = flash_reg;
    if (!en_sync_reg) begin
      current_next = `CURRENT_RESET;
      enable_next  = `ENABLE_RESET;
      flash_next   = `FLASH_RESET;
    end else if (write_now) begin
      case (sel)
        led_pkg::SEL_CURRENT: current_next = pwdata[7:0];
        led_pkg::SEL_ENABLE:  enable_next  = pwdata[3:0];
        led_pkg::SEL_FLASH:   flash_next   = pwdata[4:0];
        default:              current_next = current_reg;
      endcase
    end
  end

  // Register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_reg <= `CURRENT_RESET;
      enable_reg  <= `ENABLE_RESET;
      flash_reg   <= `FLASH_RESET;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      current_reg <= current_next;
      enable_reg  <= enable_next;
      flash_reg   <= flash_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sink controls and sleep

  logic [3:0]        bl_on_reg;
  logic [3:0]        bl_on_next;
  logic [5:0]        level_reg;
  logic [5:0]        level_next;
  logic              flash_on_next;
  logic [2:0]        flash_level_reg;
  logic [2:0]        flash_level_next;
  logic              sleep_next;
  logic [HEAD_W-1:0] min_head;

  // One shared level, each sink gated by its own enable
  always_comb begin
    bl_on_next       = enable_reg & {`SINK_COUNT{en_sync_reg}};
    level_next       = half_ma_of(current_reg[`LEVEL_MSB:0]);
    flash_on_next    = fl_sync_reg && en_sync_reg;
    flash_level_next = flash_reg[`FLASH_LEVEL_MSB:`FLASH_LEVEL_LSB];
    sleep_next       = !((|bl_on_next) || flash_on_next);
  end

  assign bl_any = |bl_on_reg;

  // Lowest headroom among the sinks that are on
  always_comb begin
    min_head = '1;
    for (int i = 0; i < `SINK_COUNT; i++) begin
      if (bl_on_reg[i] && backlight_headroom[i] < min_head) min_head = backlight_headroom[i];
    end
    if (flash_on_reg && flash_headroom < min_head) min_head = flash_headroom;
  end

  // Sink register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_on_reg       <= 4'h0;
      level_reg       <= `HALF_MA_MIN;
      flash_on_reg    <= 1'b0;
      flash_level_reg <= 3'h0;
      sleep_reg       <= 1'b1;
    end else begin
      bl_on_reg       <= bl_on_next;
      level_reg       <= level_next;
      flash_on_reg    <= flash_on_next;
      flash_level_reg <= flash_level_next;
      sleep_reg       <= sleep_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pump divider, ratio selector and switching clock

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             tick;
  logic             pump_clk_reg;
  logic             pump_clk_next;

  assign tick = !sleep_reg && div_reg == DIV_W'(`PUMP_HALF_CYCLES - 1);

  // Divider runs while awake; clock toggles only above 1x
  always_comb begin
    div_next      = (sleep_reg || tick) ? '0 : div_reg + 1'b1;
    pump_clk_next = pump_clk_reg;
    if (sleep_reg || mode_now == led_pkg::MODE_1X) pump_clk_next = 1'b0;
    else if (tick) pump_clk_next = !pump_clk_reg;
  end

  // Divider and pump clock registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg      <= '0;
      pump_clk_reg <= 1'b0;
    end else begin
      div_reg      <= div_next;
      pump_clk_reg <= pump_clk_next;
    end
  end

  // Ratio selector, paced by the divider tick
  pump_mode_select u_mode (
    .clk      (pclk),
    .rst_n    (presetn),
    .awake    (!sleep_reg),
    .tick     (tick),
    .min_head (min_head),
    .mode     (mode_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign backlight_sink_output_1 = bl_on_reg[0];
  assign backlight_sink_output_2 = bl_on_reg[1];
  assign backlight_sink_output_3 = bl_on_reg[2];
  assign backlight_sink_output_4 = bl_on_reg[3];
  assign backlight_level_half_ma = level_reg;
  assign flash_sink_output       = flash_on_reg;
  assign flash_level             = flash_level_reg;
  assign pump_mode               = mode_now;
  assign pump_clk                = pump_clk_reg;
  assign sleep_active            = sleep_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_disable_clears_regs: assert property (
    !en_sync_reg |=> enable_reg == `ENABLE_RESET && current_reg == `CURRENT_RESET && flash_reg == `FLASH_RESET)
    else $error("registers not reset while chip enable low");

  a_flash_follows_pin: assert property (
    fl_sync_reg && en_sync_reg |=> flash_sink_output)
    else $error("flash sink did not follow trigger");

  a_flash_off_low: assert property (
    !fl_sync_reg |=> !flash_sink_output)
    else $error("flash sink on while trigger low");

  a_pump_stop_1x: assert property (
    $rose(pump_clk_reg) |-> $past(mode_now) != led_pkg::MODE_1X && !$past(sleep_reg))
    else $error("pump clock rose in 1x or sleep");

  a_level_map_band: assert property (
    $changed(current_reg) |=> level_reg == half_ma_of($past(current_reg[`LEVEL_MSB:0])))
    else $error("level current does not match code");

  a_level_range: assert property (
    level_reg >= `HALF_MA_MIN && level_reg <= `HALF_MA_MAX)
    else $error("level current outside range");

  a_level_monotonic: assert property (
    $past(current_reg[`LEVEL_MSB:0]) < current_reg[`LEVEL_MSB:0] |=>
    level_reg > $past(level_reg))
    else $error("level map not monotonic");

  a_sink_needs_enable: assert property (
    (bl_on_reg & ~$past(enable_reg)) == 4'h0)
    else $error("sink on without its enable");

  a_off_after_enable: assert property (
    !$past(en_sync_reg) |-> bl_on_reg == 4'h0)
    else $error("sink on right after chip enable");

  a_sleep_stops_pump: assert property (
    sleep_reg |=> !pump_clk_reg ##0 mode_now == led_pkg::MODE_1X)
    else $error("pump active during sleep");

  a_bus_answers: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not one cycle");

  a_min_is_lowest: assert property (
    flash_on_reg |-> min_head <= flash_headroom)
    else $error("reference above flash headroom");

endmodule

// ### core/pump_mode_select.sv
// Automatic pump ratio selector with separate up and down thresholds.
// Assumes min_head comes from logic on clk and tick is a one-cycle enable.
`timescale 1ns/1ns
`include "led_params.svh"

module pump_mode_select #(
  parameter logic [7:0] UP_1 = `UP_1X_TO_1P5X,
  parameter logic [7:0] DN_1 = `DOWN_1P5X_TO_1X,
  parameter logic [7:0] UP_2 = `UP_1P5X_TO_2X,
  parameter logic [7:0] DN_2 = `DOWN_2X_TO_1P5X
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Control
  input  wire logic                   awake,
  input  wire logic                   tick,
  input  wire logic [7:0]             min_head,
  // Selected ratio
  output led_pkg::pump_mode_type      mode
);

  led_pkg::pump_mode_type mode_reg;
  led_pkg::pump_mode_type mode_next;

  // Step up on low headroom, step down only past the higher threshold
  always_comb begin
    mode_next = mode_reg;
    if (!awake) begin
      mode_next = led_pkg::MODE_1X;
    end else if (tick) begin
      case (mode_reg)
        led_pkg::MODE_1X: begin
          if (min_head < UP_1) mode_next = led_pkg::MODE_1P5X;
        end
        led_pkg::MODE_1P5X: begin
          if (min_head < UP_2) mode_next = led_pkg::MODE_2X;
          else if (min_head > DN_1) mode_next = led_pkg::MODE_1X;
        end
        led_pkg::MODE_2X: begin
          if (min_head > DN_2) mode_next = led_pkg::MODE_1P5X;
        end
        default: mode_next = led_pkg::MODE_1X;
      endcase
    end
  end

  // Ratio register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode_reg <= led_pkg::MODE_1X;
    else mode_reg <= mode_next;
  end

  assign mode = mode_reg;

  a_mode_step_up: assert property (@(posedge clk) disable iff (!rst_n)
    awake && tick && mode_reg == led_pkg::MODE_1X && min_head < UP_1 |=> mode_reg == led_pkg::MODE_1P5X)
    else $error("ratio did not step up on low headroom");

  a_mode_hyst_hold: assert property (@(posedge clk) disable iff (!rst_n)
    awake && mode_reg == led_pkg::MODE_1P5X && min_head >= UP_2 && min_head <= DN_1
    |=> mode_reg == led_pkg::MODE_1P5X)
    else $error("ratio left 1.5x inside the hysteresis band");

endmodule

// ### tb/apb_host.sv
// Host model that masters the APB register port of the LED controller.
// Assumes the slave answers with pready while psel and penable are high.
`timescale 1ns/1ns

module apb_host (
  // Clock
  input  wire logic        pclk,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  end

  // One whole transfer; waits for pready, only the bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old value
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask
endmodule

// ### tb/led_pump_backlight_control_bench.sv
// Self-checking bench for the LED pump and backlight controller.
// Assumes apb_host masters the bus and headroom words are driven here.
`timescale 1ns/1ns
`include "led_params.svh"

module led_pump_backlight_control_bench;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 chip_enable_pin = 1'b0;
  logic                 flash_trigger_pin = 1'b0;
  logic [3:0][7:0]      backlight_headroom = {4{8'h80}};
  logic [7:0]           flash_headroom = 8'h80;
  logic                 psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rdata;
  logic                 s1, s2, s3, s4, flash_on, pump_clk, sleep_active, err;
  logic [5:0]           level;
  logic [2:0]           flash_level;
  led_pkg::pump_mode_type pump_mode;
  wire  [3:0]           sinks = {s4, s3, s2, s1};
  int                   miscompares = 0;
  int                   checks_done = 0;
  int                   cycles = 0;

  // 10 MHz clock
  always #50 pclk = ~pclk;

  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                 .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  led_pump_backlight_control uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_enable_pin(chip_enable_pin), .flash_trigger_pin(flash_trigger_pin),
    .backlight_headroom(backlight_headroom), .flash_headroom(flash_headroom),
    .backlight_sink_output_1(s1), .backlight_sink_output_2(s2), .backlight_sink_output_3(s3),
    .backlight_sink_output_4(s4), .backlight_level_half_ma(level), .flash_sink_output(flash_on),
    .flash_level(flash_level), .pump_mode(pump_mode), .pump_clk(pump_clk), .sleep_active(sleep_active));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] ba(input logic [7:0] idx);
    return idx << `REG_BYTE_SHIFT;
  endfunction

  // Current in 0.5 mA units: fine steps to 12 mA, then 1 mA to 15 mA, then 2 mA
  function automatic logic [5:0] half_ma(input int c);
    if (c <= 23) return 6'(c + 1);
    if (c <= 26) return 6'(24 + 2 * (c - 23));
    return 6'(30 + 4 * (c - 26));
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    host.xfer(1'b1, a, d, rdata, err);
    check("pslverr", 32'(e), 32'(err));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    host.xfer(1'b0, a, 32'h0, rdata, err);
    check("pslverr", 32'(e), 32'(err));
    if (!e) check("prdata", exp, rdata);
  endtask

  task automatic wait_mode(input led_pkg::pump_mode_type m, input int limit);
    int n;
    n = 0;
    while (pump_mode !== m && n < limit) begin
      @(posedge pclk);
      n++;
    end
    check("pump_mode", 32'(m), 32'(pump_mode));
  endtask

  // Cycles from one falling edge of pump_clk to the next
  task automatic pump_period(output int p);
    int n;
    n = 0;
    while (pump_clk !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
    while (pump_clk === 1'b1 && n < 200) begin @(posedge pclk); n++; end
    p = 0;
    while (pump_clk === 1'b0 && p < 100) begin @(posedge pclk); p++; end
    while (pump_clk === 1'b1 && p < 200) begin @(posedge pclk); p++; end
  endtask

  task automatic stop_test;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [5:0] prev;
    int p;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chip_enable_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    check("sinks", 32'h0, 32'(sinks));
    check("sleep", 32'h1, 32'(sleep_active));
    check("pump_clk", 32'h0, 32'(pump_clk));
    check("flash_level", 32'h0, 32'(flash_level));
    rd(ba(`REG_IDX_CURRENT), 32'(`CURRENT_RESET), 1'b0);
    rd(ba(`REG_IDX_ENABLE), 32'(`ENABLE_RESET), 1'b0);
    rd(ba(`REG_IDX_FLASH), 32'(`FLASH_RESET), 1'b0);
    rd(ba(`REG_IDX_STATUS), 32'h14, 1'b0);
    // Access kinds and refusals
    wr(ba(`REG_IDX_CURRENT), 32'hffff_ffff, 1'b0);
    rd(ba(`REG_IDX_CURRENT), 32'h0000_00ff, 1'b0);
    wr(ba(`REG_IDX_FLASH), 32'h0000_000f, 1'b0);
    rd(ba(`REG_IDX_FLASH), 32'h0000_000f, 1'b0);
    check("flash_level", 32'h7, 32'(flash_level));
    wr(ba(`REG_IDX_STATUS), 32'h0, 1'b1);
    wr(8'h05, 32'hf, 1'b1);
    rd(8'h10, 32'h0, 1'b1);
    rd(ba(`REG_IDX_ENABLE), 32'h0, 1'b0);
    // Every level code
    prev = 6'h00;
    for (int c = 0; c < 32; c++) begin
      wr(ba(`REG_IDX_CURRENT), 32'(c), 1'b0);
      repeat (3) @(posedge pclk);
      check("level", 32'(half_ma(c)), 32'(level));
      check("rising", 32'h1, 32'(level > prev));
      prev = level;
    end
    // Sinks 1 and 3 in use, unused enables written as zero
    wr(ba(`REG_IDX_ENABLE), 32'h5, 1'b0);
    repeat (3) @(posedge pclk);
    check("sinks", 32'h5, 32'(sinks));
    check("level", 32'h32, 32'(level));
    check("sleep", 32'h0, 32'(sleep_active));
    // Ratio selection with an off sink showing no headroom
    backlight_headroom <= {8'h80, 8'h60, 8'h00, 8'h30};
    repeat (60) @(posedge pclk);
    check("pump_mode", 32'(led_pkg::MODE_1X), 32'(pump_mode));
    check("pump_clk", 32'h0, 32'(pump_clk));
    backlight_headroom[0] <= 8'h10;
    wait_mode(led_pkg::MODE_2X, 100);
    pump_period(p);
    check("pump_period", 32'(2 * `PUMP_HALF_CYCLES), 32'(p));
    backlight_headroom[0] <= 8'h30;
    repeat (60) @(posedge pclk);
    check("pump_mode", 32'(led_pkg::MODE_2X), 32'(pump_mode));
    backlight_headroom[0] <= 8'h39;
    wait_mode(led_pkg::MODE_1P5X, 100);
    repeat (60) @(posedge pclk);
    check("pump_mode", 32'(led_pkg::MODE_1P5X), 32'(pump_mode));
    backlight_headroom[0] <= 8'h50;
    wait_mode(led_pkg::MODE_1X, 100);
    repeat (45) @(posedge pclk);
    check("pump_clk", 32'h0, 32'(pump_clk));
    // Sleep drops the ratio at once
    backlight_headroom[0] <= 8'h10;
    wait_mode(led_pkg::MODE_2X, 100);
    wr(ba(`REG_IDX_ENABLE), 32'h0, 1'b0);
    repeat (5) @(posedge pclk);
    check("sleep", 32'h1, 32'(sleep_active));
    check("pump_mode", 32'(led_pkg::MODE_1X), 32'(pump_mode));
    check("pump_clk", 32'h0, 32'(pump_clk));
    // Flash pin and flash headroom
    flash_headroom <= 8'h10;
    flash_trigger_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    check("flash", 32'h1, 32'(flash_on));
    wait_mode(led_pkg::MODE_2X, 100);
    flash_trigger_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    check("flash", 32'h0, 32'(flash_on));
    check("pump_mode", 32'(led_pkg::MODE_1X), 32'(pump_mode));
    // Chip enable low clears registers and drops writes
    wr(ba(`REG_IDX_ENABLE), 32'hf, 1'b0);
    repeat (3) @(posedge pclk);
    check("sinks", 32'hf, 32'(sinks));
    chip_enable_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    check("sinks", 32'h0, 32'(sinks));
    rd(ba(`REG_IDX_CURRENT), 32'(`CURRENT_RESET), 1'b0);
    wr(ba(`REG_IDX_ENABLE), 32'hf, 1'b0);
    rd(ba(`REG_IDX_ENABLE), 32'(`ENABLE_RESET), 1'b0);
    chip_enable_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(ba(`REG_IDX_STATUS), 32'h14, 1'b0);
    stop_test();
  end
endmodule
